// file: src/outmode_ctrl.sv
// Command interpreter for output mode, range and triggered levels
//
// Contract
// R1: Mode query reports LIST, TRANSIENT with duration, or FIXED.
// R2: Current range takes 1 full scale or 4 quarter scale.
// R3: Current range write outside current mode raises command warning.
// R4: Stored current range kept until next function selection.
// R5: Current range query returns 1 in voltage mode.
// R6: Autoranging on after reset.
// R7: Autorange off by auto write 0 or explicit range write.
// R8: Autorange picks quarter scale at or below quarter full scale.
// R9: Triggered current stored, applied only on trigger.
// R10: Level above model maximum posts -222.
// R11: Triggered query returns last stored triggered value.
// R12: List runs with limit in force when started.
// R13: Completed list keeps next-to-last step, limit unchanged.
// R14: List loads during list run rejected with error.
// R15: List stops when count done, or on FIX, SET, OFF, LAST.
// R16: SET, OFF, LAST without running list give settings conflict.
// R17: FIX holds present output values.
// R18: SET restores pre-list values, mode FIXED.
// R19: OFF like SET and switches output off.
// R20: LAST finishes final point then FIXED.
// R21: Armed transient applies next level for nn, then reverts.
// R22: Active range command sets range of active mode, autorange off.
// R23: Transient above 10 s posts -222.
`include "outmode_map.svh"
`timescale 1ns/1ns
`default_nettype none
module outmode_ctrl
    import outmode_pkg::*;
#(
    parameter int MS_CYCLES = `OM_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        CORE_CLK_I,
    input  wire logic        SYS_RST_I,
    // Avalon-MM slave
    input  wire logic [7:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    // Output drive
    output logic      [15:0] OUT_LEVEL_O,
    output logic      [15:0] OUT_LIMIT_O,
    output logic             OUT_ON_O,
    output logic             OUT_QTR_SCALE_O
);
    // ****************************************************************
    // Bus handshake: one wait cycle, access completes in second cycle
    // ****************************************************************
    logic        ack_q;
    logic        req;
    logic        wr_go;
    logic        rd_go;
    assign req               = AVS_READ_I | AVS_WRITE_I;
    assign AVS_WAITREQUEST_O = req & ~ack_q;
    assign wr_go             = AVS_WRITE_I & ack_q;
    assign rd_go             = AVS_READ_I & ack_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    mode_e       mode_q;
    logic        cur_mode_q;
    logic [15:0] arg_q;
    logic        arg_ovr_q;
    logic [15:0] level_q;
    logic [15:0] limit_q;
    logic        out_on_q;
    logic [15:0] trig_q;
    logic [3:0]  crange_q;
    logic [3:0]  vrange_q;
    logic        auto_q;
    logic [15:0] err_q;
    logic        last_pend_q;
    logic [15:0] tran_ms_q;
    logic [15:0] ms_left_q;
    logic [31:0] tick_q;
    setting_s    saved_q;
    logic [3:0]  step_q;
    logic [3:0]  count_q;
    logic [15:0] list_lvl_q [`OM_LIST_STEPS];
    logic [15:0] prev_lvl_q;
    logic [15:0] wdata;
    cmd_e        cmd;
    logic        listing;
    logic        tick;
    logic        step_end;
    logic        final_step;
    logic [15:0] new_level;
    logic        apply_level;
    assign wdata   = AVS_WRITEDATA_I[15:0];
    assign cmd     = cmd_e'(AVS_WRITEDATA_I[3:0]);
    assign listing = (mode_q == M_LIST);
    assign tick    = (tick_q == 32'(MS_CYCLES - 1));
    assign step_end   = listing & tick & (ms_left_q == 16'h0000);
    assign final_step = (step_q == `OM_LIST_STEPS - 4'h1);
    logic cmd_go;
    assign cmd_go = wr_go & (AVS_ADDRESS_I == `OM_CMD_OFS);
    // Level beyond the model maximum, or beyond the quarter-scale span on fixed current range 4 in current mode, is refused
    logic lvl_bad;
    assign lvl_bad = arg_ovr_q || (!auto_q && cur_mode_q && crange_q == `OM_SCALE_QTR
                                   && arg_q > `OM_QTR_LIMIT); // R10
    assign apply_level = cmd_go & (((cmd == CMD_LEVEL) & ~lvl_bad) | (cmd == CMD_TRIGGER));
    assign new_level   = (cmd == CMD_TRIGGER) ? trig_q : arg_q;

    // Millisecond tick, runs while list or transient is active
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || tick || !(listing || mode_q == M_TRANS_RUN)) begin
            tick_q <= 32'h0;
        end else begin
            tick_q <= tick_q + 32'h1;
        end
    end

    // Argument latch for commands
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            arg_q     <= 16'h0000;
            arg_ovr_q <= 1'b0;
        end else if (wr_go && AVS_ADDRESS_I == `OM_ARG_OFS) begin
            arg_q     <= wdata;
            arg_ovr_q <= |AVS_WRITEDATA_I[31:16]; // R10
        end
    end

    // Limit register
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            limit_q <= 16'h0000;
        end else if (wr_go && AVS_ADDRESS_I == `OM_LIMIT_OFS && !listing) begin
            limit_q <= wdata; // R12 R13
        end
    end

    // List table load, refused while running
    always_ff @(posedge CORE_CLK_I) begin
        if (cmd_go && cmd == CMD_LISTLOAD && !listing) begin // R14
            list_lvl_q[arg_q[2:0]] <= AVS_WRITEDATA_I[31:16];
        end
    end

    // ****************************************************************
    // Mode sequencer and output levels
    // ****************************************************************
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            mode_q      <= M_FIXED;
            level_q     <= 16'h0000;
            out_on_q    <= 1'b0;
            saved_q     <= '0;
            step_q      <= 4'h0;
            count_q     <= 4'h0;
            ms_left_q   <= 16'h0000;
            last_pend_q <= 1'b0;
            prev_lvl_q  <= 16'h0000;
            tran_ms_q   <= 16'h0000;
        end else if (cmd_go && cmd == CMD_LIST && !listing) begin
            saved_q     <= '{level: level_q, limit: limit_q, out_on: out_on_q};
            mode_q      <= M_LIST; // R12
            step_q      <= 4'h0;
            count_q     <= arg_q[3:0];
            prev_lvl_q  <= level_q;
            level_q     <= list_lvl_q[0];
            ms_left_q   <= `OM_DWELL_MS;
            last_pend_q <= 1'b0;
        end else if (listing && cmd_go && cmd == CMD_FIX) begin
            mode_q <= M_FIXED; // R15 R17
        end else if (listing && cmd_go && (cmd == CMD_SET || cmd == CMD_OFF)) begin
            mode_q   <= M_FIXED; // R18
            level_q  <= saved_q.level;
            out_on_q <= (cmd == CMD_OFF) ? 1'b0 : saved_q.out_on; // R19
        end else if (listing && cmd_go && cmd == CMD_LAST) begin
            last_pend_q <= 1'b1; // R20
        end else if (step_end) begin
            ms_left_q <= `OM_DWELL_MS;
            if (final_step && (last_pend_q || count_q == 4'h1)) begin
                mode_q  <= M_FIXED; // R15 R20
                level_q <= last_pend_q ? level_q : prev_lvl_q; // R13
            end else begin
                prev_lvl_q <= level_q;
                step_q     <= final_step ? 4'h0 : step_q + 4'h1;
                count_q    <= (final_step && count_q != 4'h0) ? count_q - 4'h1 : count_q;
                level_q    <= list_lvl_q[final_step ? 3'h0 : 3'(step_q + 4'h1)];
            end
        end else if (listing && tick) begin
            ms_left_q <= ms_left_q - 16'h1;
        end else if (!listing && cmd_go && cmd == CMD_TRAN
                     && arg_q <= `OM_TRAN_MAX_MS) begin
            mode_q    <= M_TRANS_ARMED; // R21 R23
            tran_ms_q <= arg_q;
        end else if (mode_q == M_TRANS_ARMED && apply_level
                     && new_level <= `OM_LEVEL_MAX) begin
            saved_q.level <= level_q; // R21
            level_q       <= new_level;
            ms_left_q     <= tran_ms_q;
            mode_q        <= M_TRANS_RUN;
        end else if (mode_q == M_TRANS_RUN && tick) begin
            if (ms_left_q <= 16'h1) begin
                level_q <= saved_q.level; // R21
                mode_q  <= M_FIXED;
            end else begin
                ms_left_q <= ms_left_q - 16'h1;
            end
        end else if (!listing && apply_level) begin
            level_q  <= new_level; // R9
            out_on_q <= 1'b1;
        end
    end

    // Triggered level store
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            trig_q <= 16'h0000;
        end else if (cmd_go && cmd == CMD_TRIGSTORE && !lvl_bad) begin
            trig_q <= arg_q; // R9 R11
        end
    end

    // ****************************************************************
    // Ranges and function
    // ****************************************************************
    logic range_ok;
    assign range_ok = (arg_q[3:0] == `OM_SCALE_FULL) || (arg_q[3:0] == `OM_SCALE_QTR);
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            cur_mode_q <= 1'b0;
            crange_q   <= `OM_SCALE_FULL;
            vrange_q   <= `OM_SCALE_FULL;
            auto_q     <= 1'b1; // R6
        end else if (cmd_go) begin
            unique case (cmd)
                CMD_FUNC: begin
                    cur_mode_q <= arg_q[0];
                    crange_q   <= `OM_SCALE_FULL; // R4
                end
                CMD_CRANGE: if (range_ok) begin
                    crange_q <= arg_q[3:0]; // R2 R4
                    auto_q   <= 1'b0; // R7
                end
                CMD_VRANGE: if (range_ok) begin
                    if (cur_mode_q) begin
                        crange_q <= arg_q[3:0]; // R22
                    end else begin
                        vrange_q <= arg_q[3:0];
                    end
                    auto_q <= 1'b0; // R22
                end
                CMD_CAUTO, CMD_VAUTO: auto_q <= arg_q[0]; // R7
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Error posting; a new error wins over the clear on read
    // ****************************************************************
    logic [15:0] err_new;
    always_comb begin
        err_new = `OM_ERR_NONE;
        if (cmd_go) begin
            if (cmd == CMD_LISTLOAD && listing) begin
                err_new = `OM_ERR_CONFL; // R14
            end else if ((cmd == CMD_SET || cmd == CMD_OFF || cmd == CMD_LAST) && !listing) begin
                err_new = `OM_ERR_CONFL; // R16
            end else if (cmd == CMD_TRAN && arg_q > `OM_TRAN_MAX_MS) begin
                err_new = `OM_ERR_RANGE; // R23
            end else if ((cmd == CMD_LEVEL || cmd == CMD_TRIGSTORE)
                         && lvl_bad) begin
                err_new = `OM_ERR_RANGE; // R10
            end else if (cmd == CMD_CRANGE && !cur_mode_q) begin
                err_new = `OM_ERR_WARN; // R3
            end else if (cmd == CMD_CRANGE || cmd == CMD_VRANGE) begin
                err_new = range_ok ? `OM_ERR_NONE : `OM_ERR_CMD;
            end
        end
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            err_q <= `OM_ERR_NONE;
        end else if (err_new != `OM_ERR_NONE) begin
            err_q <= err_new;
        end else if (rd_go && AVS_ADDRESS_I == `OM_ERR_OFS) begin
            err_q <= `OM_ERR_NONE;
        end
    end

    // ****************************************************************
    // Range in force and read port
    // ****************************************************************
    logic [3:0] act_range;
    logic [3:0] crange_rd;
    always_comb begin
        if (auto_q) begin
            act_range = (level_q > `OM_QTR_LIMIT) ? `OM_SCALE_FULL : `OM_SCALE_QTR; // R8
        end else begin
            act_range = cur_mode_q ? crange_q : vrange_q;
        end
    end
    assign crange_rd = cur_mode_q ? act_range : `OM_SCALE_FULL; // R5

    logic [31:0] rdata;
    always_comb begin
        unique case (AVS_ADDRESS_I)
            `OM_LEVEL_OFS: rdata = {16'h0, level_q}; // R17
            `OM_TRIG_OFS:  rdata = {16'h0, trig_q}; // R11
            `OM_RANGE_OFS: rdata = {20'h0, auto_q, 3'h0, act_range, crange_rd};
            `OM_MODE_OFS:  rdata = {tran_ms_q, 14'h0, mode_q}; // R1
            `OM_ERR_OFS:   rdata = {16'h0, err_q};
            `OM_LIST_OFS:  rdata = {count_q, step_q, 7'h0, last_pend_q, ms_left_q};
            `OM_LIMIT_OFS: rdata = {16'h0, limit_q};
            `OM_STAT_OFS:  rdata = {30'h0, out_on_q, cur_mode_q};
            default:       rdata = 32'h0;
        endcase
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            AVS_READDATA_O <= 32'h0;
        end else if (AVS_READ_I && !ack_q) begin
            AVS_READDATA_O <= rdata;
        end
    end

    assign OUT_LEVEL_O     = level_q;
    assign OUT_LIMIT_O     = limit_q;
    assign OUT_ON_O        = out_on_q;
    assign OUT_QTR_SCALE_O = (act_range == `OM_SCALE_QTR);

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_range_volt_one: assert property (!cur_mode_q |-> crange_rd == `OM_SCALE_FULL) // R5
        else $error("current range not 1 in voltage mode");
    a_auto_after_rst: assert property ($fell(SYS_RST_I) |-> auto_q) // R6
        else $error("autorange not on after reset");
    a_auto_off_write: assert property (cmd_go && cmd == CMD_CAUTO && !arg_q[0] |=> !auto_q) // R7
        else $error("autorange not off");
    a_auto_pick: assert property (auto_q && level_q <= `OM_QTR_LIMIT |-> OUT_QTR_SCALE_O) // R8
        else $error("autorange picked wrong scale");
    a_trig_store: assert property (cmd_go && cmd == CMD_TRIGSTORE
                                   |=> trig_q == ($past(lvl_bad) ? $past(trig_q) : $past(arg_q))) // R11
        else $error("triggered level not stored");
    a_conflict_err: assert property (cmd_go && cmd == CMD_SET && !listing
                                     |=> err_q == `OM_ERR_CONFL) // R16
        else $error("no conflict error");
    a_off_output: assert property (listing && cmd_go && cmd == CMD_OFF |=> !OUT_ON_O && mode_q == M_FIXED) // R19
        else $error("off did not switch output off");
    a_warn_crange: assert property (cmd_go && cmd == CMD_CRANGE && !cur_mode_q
                                    |=> err_q == `OM_ERR_WARN) // R3
        else $error("no command warning");
    a_tran_limit: assert property (cmd_go && cmd == CMD_TRAN && arg_q > `OM_TRAN_MAX_MS
                                   |=> err_q == `OM_ERR_RANGE && mode_q != M_TRANS_ARMED) // R23
        else $error("long transient accepted");
    a_limit_frozen: assert property (listing |=> $stable(limit_q)) // R12
        else $error("limit changed during list");
    c_list_run: cover property (listing ##1 !listing);
    c_tran_run: cover property (mode_q == M_TRANS_RUN ##1 mode_q == M_FIXED);
    c_set_stop: cover property (listing && cmd_go && cmd == CMD_SET);
    c_trigger: cover property (cmd_go && cmd == CMD_TRIGGER);
endmodule // outmode_ctrl
`default_nettype wire

// file: inc/outmode_map.svh
// Register offsets, field values, error codes, limits and timing counts of the output mode block
`ifndef OUTMODE_MAP_SVH
`define OUTMODE_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OM_CMD_OFS      8'h00
`define OM_ARG_OFS      8'h04
`define OM_LEVEL_OFS    8'h08
`define OM_TRIG_OFS     8'h0C
`define OM_RANGE_OFS    8'h10
`define OM_MODE_OFS     8'h14
`define OM_ERR_OFS      8'h18
`define OM_LIST_OFS     8'h1C
`define OM_LIMIT_OFS    8'h20
`define OM_STAT_OFS     8'h24
// ****************************************************************
// Fields and values
// ****************************************************************
`define OM_SCALE_FULL   4'h1
`define OM_SCALE_QTR    4'h4
`define OM_LEVEL_MAX    16'hFFFF
`define OM_QTR_LIMIT    16'h4000
`define OM_ERR_NONE     16'h0000
`define OM_ERR_CMD      16'hFF9C
`define OM_ERR_CONFL    16'hFF23
`define OM_ERR_RANGE    16'hFF22
`define OM_ERR_WARN     16'hFFEA
`define OM_TRAN_MAX_MS  16'h2710
`define OM_LIST_STEPS   4'h8
// ****************************************************************
// Timing
// ****************************************************************
`define OM_CLK_HZ       25000000
`define OM_MS_NS        1000000
`define OM_CLK_NS       40
`define OM_MS_CYCLES    (`OM_MS_NS / `OM_CLK_NS)
`define OM_DWELL_MS     16'h0001
`endif

// file: inc/outmode_pkg.sv
// Types of the output mode block
package outmode_pkg;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_FIX, CMD_SET, CMD_OFF, CMD_LAST, CMD_LIST, CMD_TRAN,
        CMD_LEVEL, CMD_TRIGSTORE, CMD_TRIGGER, CMD_CRANGE, CMD_VRANGE,
        CMD_CAUTO, CMD_VAUTO, CMD_FUNC, CMD_LISTLOAD
    } cmd_e;
    typedef enum logic [1:0] {
        M_FIXED, M_LIST, M_TRANS_ARMED, M_TRANS_RUN
    } mode_e;
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] limit;
        logic        out_on;
    } setting_s;
endpackage

// file: bench/outmode_host.sv
// Host model: Avalon-MM master that issues commands to the output mode block
`timescale 1ns/1ns
`default_nettype none
module outmode_host (
    // Bus clock
    input  wire logic        CLK_I,
    // Avalon-MM master
    input  wire logic        WAITREQUEST_I,
    input  wire logic [31:0] READDATA_I,
    output var  logic [7:0]  ADDRESS_O,
    output var  logic        READ_O,
    output var  logic        WRITE_O,
    output var  logic [31:0] WRITEDATA_O
);
    initial begin
        ADDRESS_O   = 8'h00;
        READ_O      = 1'b0;
        WRITE_O     = 1'b0;
        WRITEDATA_O = 32'h00000000;
    end

    // One bus cycle; the request stands until an edge sees waitrequest low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge CLK_I);
        ADDRESS_O   <= a;
        WRITEDATA_O <= d;
        WRITE_O     <= wr;
        READ_O      <= !wr;
        do @(posedge CLK_I); while (WAITREQUEST_I !== 1'b0);
        q = READDATA_I;
        WRITE_O <= 1'b0;
        READ_O  <= 1'b0;
        // Let the completing edge settle before the caller looks at outputs
        @(negedge CLK_I);
    endtask
endmodule // outmode_host
`default_nettype wire

// file: bench/output_mode_range_control_test.sv
// Self-checking testbench of the output mode and range controller
`include "outmode_map.svh"
`timescale 1ns/1ns
`default_nettype none
module output_mode_range_control_test;
    import outmode_pkg::*;
    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wreq;
    logic [15:0] lvl;
    logic [15:0] lim;
    logic        on;
    logic        qtr;
    int          errors;
    int          total_checks;
    int          cyc;
    logic [31:0] q;
    int          n;
    logic [15:0] lv;
    logic [15:0] m_level;
    cmd_e        stop_cmds [3] = '{CMD_SET, CMD_OFF, CMD_LAST};

    // ****************************************************************
    // Design and host
    // ****************************************************************
    outmode_ctrl #(.MS_CYCLES(4)) i_outmode_ctrl (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en),
        .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .OUT_LEVEL_O(lvl), .OUT_LIMIT_O(lim), .OUT_ON_O(on),
        .OUT_QTR_SCALE_O(qtr));
    outmode_host i_outmode_host (
        .CLK_I(clk), .WAITREQUEST_I(wreq), .READDATA_I(rdata), .ADDRESS_O(addr),
        .READ_O(rd_en), .WRITE_O(wr_en), .WRITEDATA_O(wdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        cyc = 0;
        errors = 0;
        total_checks = 0;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        i_outmode_host.xfer(1'b0, a, 32'h00000000, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        i_outmode_host.xfer(1'b1, a, d, unused);
    endtask
    task automatic cmd(input cmd_e c, input logic [31:0] a, input logic [15:0] hi = 16'h0000);
        wr(`OM_ARG_OFS, a);
        wr(`OM_CMD_OFS, {hi, 12'h000, c});
        if (c == CMD_LEVEL && a <= 32'h0000FFFF) m_level = a[15:0];
    endtask
    task automatic err_is(input logic [15:0] e);
        rd(`OM_ERR_OFS);
        chk_reg("error code", {16'h0000, e}, {16'h0000, q[15:0]});
    endtask
    task automatic wait_fixed();
        n = 0;
        do begin
            rd(`OM_MODE_OFS);
            n++;
        end while (q[1:0] !== 2'h0 && n < 40);
        chk_reg("mode", 32'h00000000, {30'h00000000, q[1:0]});
    endtask
    task automatic count_back(input logic [15:0] e);
        n = 0;
        while (lvl !== e && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk_reg("transient length", 32'h00000001, {31'h00000000, (n >= 15 && n <= 22)});
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(32'h49fde009));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`OM_RANGE_OFS);
        chk_reg("autorange after reset", 32'h00000001, {31'h00000000, q[11]});
        chk_pin("level", 16'h0000, lvl);
        chk_pin("on", 16'h0000, {15'h0000, on});
        wr(8'h30, 32'hA5A5A5A5);
        rd(8'h30);
        chk_reg("unmapped", 32'h00000000, q);
        rd(`OM_ERR_OFS);
        for (int i = 0; i < 10; i++) begin
            lv = (i < 4) ? ((i == 0) ? 16'h4000 : (i == 1) ? 16'h4001 : (i == 2) ? 16'h0000
                 : 16'hFFFF) : 16'($urandom_range(0, 65535));
            cmd(CMD_LEVEL, {16'h0000, lv});
            chk_pin("level", m_level, lvl);
            chk_pin("auto scale", {15'h0000, m_level <= `OM_QTR_LIMIT}, {15'h0000, qtr});
        end
        cmd(CMD_LEVEL, 32'h00010000);
        err_is(`OM_ERR_RANGE);
        chk_pin("level kept", m_level, lvl);
        cmd(CMD_TRIGSTORE, 32'h00010000);
        err_is(`OM_ERR_RANGE);
        cmd(CMD_TRIGSTORE, 32'h00001234);
        chk_pin("level before trigger", m_level, lvl);
        rd(`OM_TRIG_OFS);
        chk_reg("stored trigger level", 32'h00001234, {16'h0000, q[15:0]});
        cmd(CMD_TRIGGER, 32'h00000000);
        chk_pin("triggered level", 16'h1234, lvl);
        cmd(CMD_CRANGE, 32'h00000004);
        err_is(`OM_ERR_WARN);
        rd(`OM_RANGE_OFS);
        chk_reg("current range in voltage mode", 32'h1, {28'h0, q[3:0]});
        cmd(CMD_FUNC, 32'h00000001);
        cmd(CMD_LEVEL, 32'h00003000);
        cmd(CMD_CRANGE, 32'h00000004);
        rd(`OM_RANGE_OFS);
        chk_reg("current range", 32'h4, {28'h0, q[3:0]});
        chk_reg("auto off", 32'h0, {31'h0, q[11]});
        chk_pin("quarter scale", 16'h0001, {15'h0000, qtr});
        cmd(CMD_LEVEL, 32'h00005000);
        err_is(`OM_ERR_RANGE);
        chk_pin("level beyond quarter", 16'h3000, lvl);
        cmd(CMD_CRANGE, 32'h00000001);
        chk_pin("full scale", 16'h0000, {15'h0000, qtr});
        cmd(CMD_CRANGE, 32'h00000007);
        err_is(`OM_ERR_CMD);
        cmd(CMD_FUNC, 32'h00000000);
        rd(`OM_RANGE_OFS);
        chk_reg("range after function", 32'h1, {28'h0, q[3:0]});
        for (int k = 0; k < 2; k++) begin
            cmd(k ? CMD_VAUTO : CMD_CAUTO, 32'h00000001);
            cmd(k ? CMD_CAUTO : CMD_VAUTO, 32'h00000000);
            rd(`OM_RANGE_OFS);
            chk_reg("auto cleared", 32'h0, {31'h0, q[11]});
        end
        cmd(CMD_CAUTO, 32'h00000001);
        cmd(CMD_LEVEL, 32'h0000FFFF);
        cmd(CMD_VRANGE, 32'h00000004);
        rd(`OM_RANGE_OFS);
        chk_reg("active range", 32'h4, {28'h0, q[7:4]});
        chk_reg("auto off by range", 32'h0, {31'h0, q[11]});
        chk_pin("quarter scale", 16'h0001, {15'h0000, qtr});
        cmd(CMD_CAUTO, 32'h00000001);
        rd(`OM_ERR_OFS);
        foreach (stop_cmds[k]) begin
            cmd(stop_cmds[k], 32'h00000000);
            err_is(`OM_ERR_CONFL);
        end
        cmd(CMD_FIX, 32'h00000000);
        err_is(`OM_ERR_NONE);
        for (int i = 0; i < 8; i++) cmd(CMD_LISTLOAD, i, 16'h0100 * (i + 1));
        cmd(CMD_LEVEL, 32'h00000777);
        for (int k = 0; k < 2; k++) begin
            cmd(CMD_LIST, 32'h00000000);
            rd(`OM_MODE_OFS);
            chk_reg("list mode", 32'h1, {30'h0, q[1:0]});
            cmd(CMD_LISTLOAD, 32'h00000000, 16'h0900);
            rd(`OM_ERR_OFS);
            chk_reg("load refused", 32'h1, {31'h0, q[15:0] === `OM_ERR_CMD
                    || q[15:0] === `OM_ERR_CONFL});
            cmd(k ? CMD_OFF : CMD_SET, 32'h00000000);
            wait_fixed();
            chk_pin("restored level", 16'h0777, lvl);
            chk_pin("output off", {15'h0000, k == 0}, {15'h0000, on});
        end
        cmd(CMD_LIST, 32'h00000000);
        cmd(CMD_FIX, 32'h00000000);
        wait_fixed();
        chk_reg("held list level", 32'h1, {31'h0, lvl[7:0] === 8'h00
                && lvl >= 16'h0100 && lvl <= 16'h0800});
        cmd(CMD_LIST, 32'h00000000);
        cmd(CMD_LAST, 32'h00000000);
        wait_fixed();
        chk_pin("final point", 16'h0800, lvl);
        cmd(CMD_LEVEL, 32'h00000777);
        wr(`OM_LIMIT_OFS, 32'h0000ABCD);
        cmd(CMD_LIST, 32'h00000001);
        wr(`OM_LIMIT_OFS, 32'h00001111);
        wait_fixed();
        chk_pin("completed list level", 16'h0700, lvl);
        chk_pin("limit kept", 16'hABCD, lim);
        cmd(CMD_LEVEL, 32'h00002000);
        cmd(CMD_TRAN, 32'h00000005);
        rd(`OM_MODE_OFS);
        chk_reg("armed mode", 32'h00050002, {q[31:16], 14'h0, q[1:0]});
        cmd(CMD_LEVEL, 32'h00003000);
        chk_pin("pulse level", 16'h3000, lvl);
        count_back(16'h2000);
        cmd(CMD_TRIGSTORE, 32'h00001500);
        cmd(CMD_TRAN, 32'h00000005);
        cmd(CMD_TRIGGER, 32'h00000000);
        chk_pin("triggered pulse", 16'h1500, lvl);
        count_back(16'h2000);
        wait_fixed();
        cmd(CMD_TRAN, 32'h00002711);
        err_is(`OM_ERR_RANGE);
        cmd(CMD_CAUTO, 32'h00000000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(`OM_RANGE_OFS);
        chk_reg("autorange after second reset", 32'h1, {31'h0, q[11]});
        report_and_stop();
    end
endmodule // output_mode_range_control_test
`default_nettype wire
